// ### src/tcc_pkg.sv
// Constants for the capture/compare channel block.
// Assumes an APB master and a timer counter on the same clock.
package tcc_pkg;
    // ****************************************
    // Sizes
    // ****************************************
    localparam int unsigned NCH_MAX = 6;
    localparam int unsigned OVF_BIT = 6;

    // ****************************************
    // Register offsets
    // ****************************************
    localparam logic [7:0] CTRL_BASE  = 8'h00;
    localparam logic [7:0] VALUE_BASE = 8'h20;
    localparam logic [7:0] IVEC_OFF   = 8'h40;
    localparam logic [7:0] MASK_OFF   = 8'h44;
    localparam logic [7:0] STAT_OFF   = 8'h48;
    localparam logic [7:0] CH_STRIDE  = 8'h04;

    // ****************************************
    // Control field positions
    // ****************************************
    localparam int unsigned EDGE_LO  = 14;
    localparam int unsigned SYNC_BIT = 11;
    localparam int unsigned LLD_LO   = 9;
    localparam int unsigned CAP_BIT  = 8;
    localparam int unsigned OM_LO    = 5;
    localparam int unsigned IE_BIT   = 4;
    localparam int unsigned IN_BIT   = 3;
    localparam int unsigned OUT_BIT  = 2;
    localparam int unsigned COV_BIT  = 1;
    localparam int unsigned FLG_BIT  = 0;
    localparam logic [15:0] CTRL_RST = 16'h0000;
    localparam logic [15:0] CTRL_RW  = 16'hFFF4;

    // ****************************************
    // Codes
    // ****************************************
    localparam logic [1:0] LLD_IMM  = 2'h0;
    localparam logic [1:0] LLD_ZERO = 2'h1;
    localparam logic [1:0] LLD_ZP   = 2'h2;
    localparam logic [1:0] LLD_ZPUD = 2'h3;
    localparam logic [1:0] CM_UP    = 2'h1;
    localparam logic [1:0] CM_CONT  = 2'h2;
    localparam logic [1:0] CM_UPDN  = 2'h3;
    localparam logic [2:0] OM_BIT   = 3'h0;
    localparam logic [2:0] OM_SET   = 3'h1;
    localparam logic [2:0] OM_TGRS  = 3'h2;
    localparam logic [2:0] OM_SETRS = 3'h3;
    localparam logic [2:0] OM_TGL   = 3'h4;
    localparam logic [2:0] OM_RST   = 3'h5;
    localparam logic [2:0] OM_TGST  = 3'h6;
    localparam logic [2:0] OM_RSTST = 3'h7;
    localparam logic [15:0] IV_NONE = 16'h0000;
    localparam logic [15:0] IV_OVF  = 16'h000E;

    typedef enum logic {APB_IDLE, APB_ACK} tcc_apb_type;
endpackage

// ### src/tcc_channel.sv
// One capture/compare channel.
// Assumes synchronised input level and same-clock counter signals.
`timescale 1ns/1ps
`default_nettype none
module tcc_channel (
    // Clock and reset
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        ce,
    // Register access
    input  wire logic        ctrl_wr,
    input  wire logic        value_wr,
    input  wire logic [15:0] wdata,
    input  wire logic        flag_clr,
    // Timer
    input  wire logic [15:0] counter_value,
    input  wire logic [1:0]  count_mode,
    input  wire logic        zero_hit,
    input  wire logic        period_match,
    input  wire logic        cnt_moved,
    input  wire logic        in_level,
    // Results
    output logic [15:0]      ctrl_rd,
    output logic [15:0]      value_rd,
    output logic             out_level,
    output logic             flag
);
    logic [15:0] ctrl_reg;
    logic [15:0] value_reg;
    logic [15:0] compare_latch;
    logic        flag_reg;
    logic        cov_reg;
    logic        out_reg;
    logic        in_q_reg;
    logic        in_prev_reg;
    logic        in_sel;
    logic        cap_ev;
    logic        eq_ev;
    logic        load_ev;
    logic        capture_select;
    logic [1:0]  latch_load_sel;
    logic [2:0]  output_mode_field;
    logic [1:0]  edge_sel;

    assign capture_select    = ctrl_reg[tcc_pkg::CAP_BIT];
    assign latch_load_sel    = ctrl_reg[tcc_pkg::LLD_LO +: 2];
    assign output_mode_field = ctrl_reg[tcc_pkg::OM_LO +: 3];
    assign edge_sel          = ctrl_reg[tcc_pkg::EDGE_LO +: 2];

    // ****************************************
    // Capture input
    // ****************************************
    // sync or direct capture
    assign in_sel = ctrl_reg[tcc_pkg::SYNC_BIT] ? in_q_reg : in_level;
    assign cap_ev = capture_select && ((edge_sel[0] && in_sel && !in_prev_reg)
                    || (edge_sel[1] && !in_sel && in_prev_reg));
    assign eq_ev  = !capture_select && cnt_moved && (counter_value == compare_latch);

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            in_q_reg    <= 1'b0;
            in_prev_reg <= 1'b0;
        end else if (ce) begin
            in_q_reg    <= in_level;
            in_prev_reg <= in_sel;
        end
    end

    // ****************************************
    // Control and flags
    // ****************************************
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_reg <= tcc_pkg::CTRL_RST;
        end else if (ce && ctrl_wr) begin
            ctrl_reg <= wdata & tcc_pkg::CTRL_RW;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            flag_reg <= 1'b0;
        end else if (ce) begin
            if (cap_ev || eq_ev || (ctrl_wr && wdata[tcc_pkg::FLG_BIT])) begin
                flag_reg <= 1'b1;
            end else if (flag_clr || ctrl_wr) begin
                flag_reg <= 1'b0;
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cov_reg <= 1'b0;
        end else if (ce) begin
            if (cap_ev && flag_reg) begin
                cov_reg <= 1'b1;
            end else if (ctrl_wr && !wdata[tcc_pkg::COV_BIT]) begin
                cov_reg <= 1'b0;
            end
        end
    end

    // ****************************************
    // Value and latch
    // ****************************************
    // capture copies counter
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            value_reg <= 16'h0000;
        end else if (ce) begin
            if (cap_ev) begin
                value_reg <= counter_value;
            end else if (value_wr) begin
                value_reg <= wdata;
            end
        end
    end

    always_comb begin
        load_ev = 1'b0;
        case (latch_load_sel)
            tcc_pkg::LLD_ZERO: load_ev = zero_hit;
            tcc_pkg::LLD_ZP: load_ev = (count_mode == tcc_pkg::CM_UPDN) ? (zero_hit || period_match)
                : (((count_mode == tcc_pkg::CM_UP) || (count_mode == tcc_pkg::CM_CONT)) && zero_hit);
            tcc_pkg::LLD_ZPUD: load_ev = (count_mode == tcc_pkg::CM_UPDN) && (zero_hit || period_match);
            default: load_ev = 1'b0;
        endcase
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            compare_latch <= 16'h0000;
        end else if (ce && !capture_select) begin
            if (latch_load_sel == tcc_pkg::LLD_IMM && value_wr) begin
                compare_latch <= wdata;
            end else if (load_ev) begin
                compare_latch <= value_reg;
            end
        end
    end

    // ****************************************
    // Output unit
    // ****************************************
    // output mode actions
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            out_reg <= 1'b0;
        end else if (ce) begin
            case (output_mode_field)
                tcc_pkg::OM_BIT: out_reg <= ctrl_reg[tcc_pkg::OUT_BIT];
                tcc_pkg::OM_SET: if (eq_ev) out_reg <= 1'b1;
                tcc_pkg::OM_TGRS: if (eq_ev) out_reg <= !out_reg; else if (period_match) out_reg <= 1'b0;
                tcc_pkg::OM_SETRS: if (eq_ev) out_reg <= 1'b1; else if (period_match) out_reg <= 1'b0;
                tcc_pkg::OM_TGL: if (eq_ev) out_reg <= !out_reg;
                tcc_pkg::OM_RST: if (eq_ev) out_reg <= 1'b0;
                tcc_pkg::OM_TGST: if (eq_ev) out_reg <= !out_reg; else if (period_match) out_reg <= 1'b1;
                default: if (eq_ev) out_reg <= 1'b0; else if (period_match) out_reg <= 1'b1;
            endcase
        end
    end

    always_comb begin
        ctrl_rd = ctrl_reg;
        ctrl_rd[tcc_pkg::IN_BIT]  = in_sel;
        ctrl_rd[tcc_pkg::COV_BIT] = cov_reg;
        ctrl_rd[tcc_pkg::FLG_BIT] = flag_reg;
    end
    assign value_rd  = value_reg;
    assign out_level = out_reg;
    assign flag      = flag_reg;

    // ****************************************
    // Checks
    // ****************************************
    a_cov_set: assert property (@(posedge pclk) disable iff (!presetn)
        (ce && cap_ev && flag_reg) |=> cov_reg) else $error("overflow not flagged");
    a_cov_hold: assert property (@(posedge pclk) disable iff (!presetn)
        (cov_reg && !(ce && ctrl_wr && !wdata[tcc_pkg::COV_BIT])) |=> cov_reg) else $error("overflow lost");
    a_cap_value: assert property (@(posedge pclk) disable iff (!presetn)
        (ce && cap_ev) |=> (value_reg == $past(counter_value))) else $error("capture value wrong");
    a_latch_imm: assert property (@(posedge pclk) disable iff (!presetn)
        (ce && value_wr && !capture_select && latch_load_sel == tcc_pkg::LLD_IMM)
        |=> (compare_latch == $past(wdata))) else $error("latch not loaded");
    a_mode0_out: assert property (@(posedge pclk) disable iff (!presetn)
        (ce && output_mode_field == tcc_pkg::OM_BIT) |=> (out_reg == $past(ctrl_reg[tcc_pkg::OUT_BIT])))
        else $error("direct output wrong");
endmodule
`default_nettype wire

// ### src/tcc_top.sv
// Capture/compare channel group with APB registers and vector.
// Assumes counter signals on pclk; capture pins are asynchronous.
//
// Design decisions made here: the APB slave port and the register addresses.
`timescale 1ns/1ps
`default_nettype none
// Summary of operation
// - bit 11 picks synchronised or direct capture
// - bits 10-9 pick latch load; 01 at zero
// - code 10 zero, or period/zero in up/down
// - zero-only variant only in up/continuous
// - bit 8 selects compare or capture
// - bits 7-5 choose eight output actions
// - bit 4 gates the channel interrupt
// - bit 3 reads selected input level
// - mode zero drives output from bit 2
// - overflow bit set by hardware, software clears
// - bit 0 shows channel interrupt pending
// - vector 00 none, 02-0C channels, 0E overflow
// - channels two to six are optional
// - compare writes reach the compare latch
// - capture copies counter into value register
module tcc_top #(
    parameter int unsigned NCH = 6
) (
    // Clock and reset
    input  wire logic           pclk,
    input  wire logic           presetn,
    input  wire logic           ce,
    // APB slave
    input  wire logic           psel,
    input  wire logic           penable,
    input  wire logic           pwrite,
    input  wire logic [7:0]     paddr,
    input  wire logic [31:0]    pwdata,
    output logic [31:0]         prdata,
    output logic                pready,
    output logic                pslverr,
    // Timer counter
    input  wire logic [15:0]    counter_value,
    input  wire logic [1:0]     count_mode,
    input  wire logic [15:0]    period_latch,
    input  wire logic           counter_overflow,
    // Channel pins
    input  wire logic [NCH-1:0] capture_in,
    output logic [NCH-1:0]      channel_out,
    output logic                irq
);
    localparam int unsigned NM = tcc_pkg::NCH_MAX;

    // APB handshake state

    tcc_pkg::tcc_apb_type apb_state;
    logic [31:0]   prdata_reg;
    logic          pready_reg;
    logic          pslverr_reg;
    logic          irq_reg;
    logic [NM:0]   mask_reg;
    logic          counter_overflow_flag;
    logic [15:0]   cnt_prev_reg;
    logic [NCH-1:0] sync1_reg;
    logic [NCH-1:0] sync2_reg;
    logic [2:0]    vec_idx_reg;
    logic          vec_valid_reg;
    logic [15:0]   ctrl_rd  [NM];
    logic [15:0]   value_rd [NM];
    logic [NM-1:0] flags;
    logic [NM-1:0] ie;
    logic [NM-1:0] ctrl_wr;
    logic [NM-1:0] value_wr;
    logic [NM-1:0] flag_clr;
    logic [NM:0]   pend;
    logic [NM:0]   stat;
    logic          done;
    logic          zero_hit;
    logic          period_match;
    logic          cnt_moved;
    logic [31:0]   rd_data;
    logic          rd_hit;
    logic [2:0]    vec_idx;
    logic          vec_valid;
    logic [15:0]   irq_vector_code;

    // ****************************************
    // Helpers
    // ****************************************
    function automatic logic ch_hit(input logic [7:0] addr, input logic [7:0] base, input int unsigned i);
        ch_hit = (addr == base + 8'(i * 4));
    endfunction

    function automatic logic [3:0] vec_pick(input logic [NM:0] p);
        vec_pick = 4'h0;
        for (int i = NM; i >= 0; i--) begin
            if (p[i]) begin
                vec_pick = {1'b1, 3'(i)};
            end
        end
    endfunction

    // ****************************************
    // Counter events and pin sync
    // ****************************************
    assign cnt_moved    = (counter_value != cnt_prev_reg);
    assign zero_hit     = cnt_moved && (counter_value == 16'h0000);
    assign period_match = cnt_moved && (counter_value == period_latch);

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cnt_prev_reg <= 16'h0000;
            sync1_reg    <= '0;
            sync2_reg    <= '0;
        end else if (ce) begin
            cnt_prev_reg <= counter_value;
            sync1_reg    <= capture_in;
            sync2_reg    <= sync1_reg;
        end
    end

    // ****************************************
    // Channels
    // ****************************************
    // omitted channels read zero
    for (genvar g = 0; g < NM; g++) begin : gen_ch
        if (g < NCH) begin : gen_on
            tcc_channel u_ch (
                .pclk          (pclk),
                .presetn       (presetn),
                .ce            (ce),
                .ctrl_wr       (ctrl_wr[g]),
                .value_wr      (value_wr[g]),
                .wdata         (pwdata[15:0]),
                .flag_clr      (flag_clr[g]),
                .counter_value (counter_value),
                .count_mode    (count_mode),
                .zero_hit      (zero_hit),
                .period_match  (period_match),
                .cnt_moved     (cnt_moved),
                .in_level      (sync2_reg[g]),
                .ctrl_rd       (ctrl_rd[g]),
                .value_rd      (value_rd[g]),
                .out_level     (channel_out[g]),
                .flag          (flags[g])
            );
        end else begin : gen_off
            assign ctrl_rd[g]  = 16'h0000;
            assign value_rd[g] = 16'h0000;
            assign flags[g]    = 1'b0;
        end
        assign ie[g]       = ctrl_rd[g][tcc_pkg::IE_BIT];
        assign ctrl_wr[g]  = done && pwrite && ch_hit(paddr, tcc_pkg::CTRL_BASE, g);
        assign value_wr[g] = done && pwrite && ch_hit(paddr, tcc_pkg::VALUE_BASE, g);
        assign flag_clr[g] = done && ((!pwrite && paddr == tcc_pkg::IVEC_OFF && vec_valid_reg
                             && vec_idx_reg == 3'(g))
                             || (pwrite && paddr == tcc_pkg::STAT_OFF && pwdata[g]));
    end

    // ****************************************
    // Interrupts
    // ****************************************
    // enable gates channel request
    assign pend = {counter_overflow_flag, flags & ie};
    assign stat = {counter_overflow_flag, flags};
    assign {vec_valid, vec_idx} = vec_pick(pend);
    assign irq_vector_code = !vec_valid ? tcc_pkg::IV_NONE
                           : (vec_idx == 3'(NM)) ? tcc_pkg::IV_OVF
                           : {12'h000, vec_idx + 3'h1, 1'b0};

    // Overflow flag, set wins over clear
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            counter_overflow_flag <= 1'b0;
        end else if (ce) begin
            if (counter_overflow) begin
                counter_overflow_flag <= 1'b1;
            end else if (done && ((!pwrite && paddr == tcc_pkg::IVEC_OFF && vec_valid_reg
                         && vec_idx_reg == 3'(NM))
                         || (pwrite && paddr == tcc_pkg::STAT_OFF && pwdata[tcc_pkg::OVF_BIT]))) begin
                counter_overflow_flag <= 1'b0;
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            mask_reg <= '0;
        end else if (ce && done && pwrite && paddr == tcc_pkg::MASK_OFF) begin
            mask_reg <= pwdata[NM:0];
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq_reg <= 1'b0;
        end else if (ce) begin
            irq_reg <= |(pend & mask_reg);
        end
    end

    // ****************************************
    // APB slave
    // ****************************************
    always_comb begin
        rd_data = 32'h0000_0000;
        rd_hit  = 1'b0;
        if (paddr == tcc_pkg::IVEC_OFF) begin
            rd_data = {16'h0000, irq_vector_code};
            rd_hit  = 1'b1;
        end else if (paddr == tcc_pkg::MASK_OFF) begin
            rd_data = 32'(mask_reg);
            rd_hit  = 1'b1;
        end else if (paddr == tcc_pkg::STAT_OFF) begin
            rd_data = 32'(stat);
            rd_hit  = 1'b1;
        end else begin
            for (int i = 0; i < NM; i++) begin
                if (ch_hit(paddr, tcc_pkg::CTRL_BASE, i)) begin
                    rd_data = {16'h0000, ctrl_rd[i]};
                    rd_hit  = 1'b1;
                end else if (ch_hit(paddr, tcc_pkg::VALUE_BASE, i)) begin
                    rd_data = {16'h0000, value_rd[i]};
                    rd_hit  = 1'b1;
                end
            end
        end
    end

    assign done = (apb_state == tcc_pkg::APB_ACK) && psel && penable;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            apb_state     <= tcc_pkg::APB_IDLE;
            prdata_reg    <= 32'h0000_0000;
            pready_reg    <= 1'b0;
            pslverr_reg   <= 1'b0;
            vec_idx_reg   <= 3'h0;
            vec_valid_reg <= 1'b0;
        end else if (ce) begin
            case (apb_state)
                tcc_pkg::APB_IDLE: begin
                    if (psel && !penable) begin
                        apb_state     <= tcc_pkg::APB_ACK;
                        prdata_reg    <= pwrite ? 32'h0000_0000 : rd_data;
                        pslverr_reg   <= !rd_hit;
                        pready_reg    <= 1'b1;
                        vec_idx_reg   <= vec_idx;
                        vec_valid_reg <= vec_valid;
                    end
                end
                default: begin
                    apb_state   <= tcc_pkg::APB_IDLE;
                    pready_reg  <= 1'b0;
                    pslverr_reg <= 1'b0;
                end
            endcase
        end
    end

    assign prdata  = prdata_reg;
    assign pready  = pready_reg;
    assign pslverr = pslverr_reg;
    assign irq     = irq_reg;

    // ****************************************
    // Checks
    // ****************************************
    a_irq_level: assert property (@(posedge pclk) disable iff (!presetn)
        $past(ce) |-> (irq_reg == $past(|(pend & mask_reg)))) else $error("irq level wrong");
    a_ready_pulse: assert property (@(posedge pclk) disable iff (!presetn)
        (ce && pready_reg) |=> !pready_reg) else $error("pready held");
    a_vec_none: assert property (@(posedge pclk) disable iff (!presetn)
        (ce && psel && !penable && !pwrite && apb_state == tcc_pkg::APB_IDLE
        && paddr == tcc_pkg::IVEC_OFF && pend == '0) |=> (prdata_reg == 32'h0000_0000))
        else $error("vector not zero");
    a_vec_first: assert property (@(posedge pclk) disable iff (!presetn)
        (ce && psel && !penable && !pwrite && apb_state == tcc_pkg::APB_IDLE
        && paddr == tcc_pkg::IVEC_OFF && pend[0]) |=> (prdata_reg[15:0] == 16'h0002))
        else $error("channel one not first");
    a_vec_clear: assert property (@(posedge pclk) disable iff (!presetn)
        (ce && done && !pwrite && paddr == tcc_pkg::IVEC_OFF && vec_valid_reg
        && vec_idx_reg == 3'h0 && !gen_ch[0].gen_on.u_ch.cap_ev && !gen_ch[0].gen_on.u_ch.eq_ev)
        |=> !flags[0]) else $error("vector read kept flag");
endmodule
`default_nettype wire

// ### tb/testbench.sv
// Self-checking bench for the capture/compare channel group.
// Assumes tcc_top answers each APB setup one cycle later.
`timescale 1ns/1ps
`default_nettype none
module testbench;
    // ****************************************
    // Signals
    // ****************************************
    logic        pclk = 1'h0, presetn = 1'h0, psel = 1'h0, penable = 1'h0, pwrite = 1'h0;
    logic        ovf = 1'h0, pready, pslverr, irq, e;
    logic [7:0]  paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, prdata, r;
    logic [15:0] cnt = 16'h0000;
    logic [1:0]  cm = 2'h1;
    logic [5:0]  cap = 6'h00, chout;
    int          n_fail = 0, comparisons = 0;
    always #50 pclk = ~pclk;
    tcc_top #(.NCH(6)) tcc_top_i (.pclk(pclk), .presetn(presetn), .ce(1'h1), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .counter_value(cnt), .count_mode(cm),
        .period_latch(16'hFFFF), .counter_overflow(ovf), .capture_in(cap), .channel_out(chout), .irq(irq));
    // ****************************************
    // Tasks
    // ****************************************
    task automatic close_out;
        $display("Counts: %0d mismatches, %0d comparisons", n_fail, comparisons);
        if (n_fail == 0 && comparisons > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask
    task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
        comparisons++;
        if (got !== exp) begin
            $display("Error %s expected %h seen %h", name, exp, got);
            n_fail++;
        end
    endtask
    task automatic xfer(input logic w, input logic [7:0] a, input logic [15:0] d);
        int k;
        k = 0;
        psel    <= 1'h1;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= {16'h0000, d};
        @(posedge pclk);
        penable <= 1'h1;
        do begin
            @(posedge pclk);
            k++;
        end while (pready !== 1'h1 && k < 20);
        if (pready !== 1'h1) begin
            chk("pready", 32'h1, 32'h0);
            close_out();
        end
        r = prdata;
        e = pslverr;
        psel    <= 1'h0;
        penable <= 1'h0;
        @(posedge pclk);
    endtask
    task automatic wait_flag(input logic [7:0] a);
        int k;
        k = 0;
        do begin
            xfer(1'h0, a, 16'h0000);
            k++;
        end while (r[0] !== 1'h1 && k < 20);
        chk("flag", 32'h1, {31'h0, r[0]});
        if (r[0] !== 1'h1) begin
            close_out();
        end
    endtask
    // ****************************************
    // Sequence
    // ****************************************
    initial begin
        repeat (10) @(posedge pclk);
        presetn <= 1'h1;
        @(posedge pclk);
        xfer(1'h0, 8'h00, 16'h0000);
        chk("ctrl reset", 32'h0, r & 32'hFFF7);
        xfer(1'h0, 8'h40, 16'h0000);
        chk("vector idle", 32'h0, r);
        xfer(1'h0, 8'h80, 16'h0000);
        chk("unmapped err", 32'h1, {31'h0, e});
        xfer(1'h1, 8'h08, 16'hFE70);
        xfer(1'h0, 8'h08, 16'h0000);
        chk("ctrl fields", 32'hFE70, r & 32'hFFF7);
        for (int m = 0; m < 8; m++) begin
            xfer(1'h1, 8'h0C, {8'h00, m[2:0], 5'h00});
            xfer(1'h0, 8'h0C, 16'h0000);
            chk("output mode", {24'h0, m[2:0], 5'h00}, r & 32'hFFF7);
        end
        xfer(1'h1, 8'h04, 16'h0004);
        xfer(1'h0, 8'h04, 16'h0000);
        chk("direct out", 32'h1, {31'h0, chout[1]});
        $display("Test fields done");
        xfer(1'h1, 8'h44, 16'h007F);
        xfer(1'h1, 8'h00, 16'h0010);
        xfer(1'h1, 8'h04, 16'h00B0);
        xfer(1'h1, 8'h20, 16'h0040);
        xfer(1'h1, 8'h24, 16'h0040);
        cnt <= 16'h0040;
        wait_flag(8'h04);
        chk("reset out", 32'h0, {31'h0, chout[1]});
        chk("irq", 32'h1, {31'h0, irq});
        for (int i = 1; i < 4; i++) begin
            xfer(1'h0, 8'h40, 16'h0000);
            chk("vector", (i == 3) ? 32'h0 : 32'(2 * i), r);
        end
        ovf <= 1'h1;
        @(posedge pclk);
        ovf <= 1'h0;
        @(posedge pclk);
        xfer(1'h0, 8'h48, 16'h0000);
        chk("status", 32'h40, r);
        xfer(1'h1, 8'h44, 16'h0000);
        @(posedge pclk);
        chk("masked irq", 32'h0, {31'h0, irq});
        xfer(1'h0, 8'h40, 16'h0000);
        chk("vector ovf", 32'hE, r);
        $display("Test vector done");
        xfer(1'h1, 8'h00, 16'h4910);
        cnt <= 16'h1234;
        cap <= 6'h01;
        wait_flag(8'h00);
        xfer(1'h0, 8'h20, 16'h0000);
        chk("capture", 32'h1234, r);
        cap <= 6'h00;
        cnt <= 16'h2222;
        repeat (4) @(posedge pclk);
        cap <= 6'h01;
        repeat (8) @(posedge pclk);
        xfer(1'h0, 8'h00, 16'h0000);
        chk("cov and input", 32'hB, r & 32'hB);
        xfer(1'h1, 8'h00, 16'h4110);
        xfer(1'h0, 8'h00, 16'h0000);
        chk("cov clear", 32'h0, r & 32'h3);
        $display("Test capture done");
        xfer(1'h1, 8'h10, 16'h0210);
        xfer(1'h1, 8'h30, 16'h0050);
        cnt <= 16'h0050;
        repeat (4) @(posedge pclk);
        xfer(1'h0, 8'h10, 16'h0000);
        chk("latch held", 32'h0, r & 32'h1);
        cnt <= 16'h0000;
        repeat (4) @(posedge pclk);
        xfer(1'h1, 8'h10, 16'h0210);
        cnt <= 16'h0050;
        wait_flag(8'h10);
        $display("Test latch done");
        xfer(1'h1, 8'h14, 16'h0410);
        xfer(1'h1, 8'h34, 16'h0077);
        cnt <= 16'hFFFF;
        repeat (2) @(posedge pclk);
        cnt <= 16'h0077;
        repeat (4) @(posedge pclk);
        xfer(1'h0, 8'h14, 16'h0000);
        chk("up period held", 32'h0, r & 32'h1);
        cm  <= 2'h3;
        cnt <= 16'hFFFF;
        repeat (2) @(posedge pclk);
        cnt <= 16'h0077;
        wait_flag(8'h14);
        $display("Test updown done");
        close_out();
    end
endmodule
`default_nettype wire
